// [include/odc_defs.svh]
// Constants for the output channel divider configuration block
//
// Function
// - Switch bit, reset 1: 0 applies changes at once, 1 glitch-free.
// - Supply bit, reset 1: set is 1.8 V, clear is 2.5 V or 3.3 V.
// - Upper 16 fraction bits come from one field, also used in delay mode.
// - Lower 9 fraction bits come from next register bits 8-0, in both modes.
// - Selector 0 to 3 picks prescaler A, prescaler B, fraction or reference.
// - Integer divider divides by a 14-bit value; zero powers it down.
// - Alignment delays the channel by 0 to 31 cycles of the divider input.
// - The channel aligns only when its enable bit is 1, which resets to 0.
// - Muted with level select 0, output P is low and output N high.
// - Mute bit acts directly under override, otherwise only in calibration.
// - Mode bit selects fraction synthesis at 0 and delay mode at 1.
`ifndef ODC_DEFS_SVH
`define ODC_DEFS_SVH

`define ODC_ADDR_W 8
`define ODC_DATA_W 16
`define ODC_DIV_W 14
`define ODC_DLY_W 5

`define ODC_OFF_SW_CTRL 8'h2D
`define ODC_OFF_SUPPLY 8'h2E
`define ODC_OFF_FRAC_HI 8'h2F
`define ODC_OFF_FRAC_LO 8'h30
`define ODC_OFF_INT_DIV 8'h31
`define ODC_OFF_SYNC_OUT 8'h32

`define ODC_RST_SW_CTRL 16'h0071
`define ODC_RST_SUPPLY 16'h0008
`define ODC_RST_FRAC_HI 16'h8000
`define ODC_RST_FRAC_LO 16'h0000
`define ODC_RST_INT_DIV 16'h0000
`define ODC_RST_SYNC_OUT 16'h0004

`define ODC_SW_SMOOTH_BIT 0
`define ODC_SW_DELAY_MODE_BIT 15
`define ODC_SUP_LOW_BIT 3
`define ODC_LO_MSB 8
`define ODC_IDIV_MSB 13
`define ODC_ISRC_MSB 15
`define ODC_ISRC_LSB 14
`define ODC_DLY_MSB 15
`define ODC_DLY_LSB 11
`define ODC_ALIGN_EN_BIT 10
`define ODC_SIL_LVL_BIT 8
`define ODC_SIL_BIT 7

`endif

// [include/odc_pkg.sv]
// Types for the output channel divider configuration block
package odc_pkg;
  typedef enum logic [1:0] {
    ODC_SRC_PRESCALER_A = 2'h0,
    ODC_SRC_PRESCALER_B = 2'h1,
    ODC_SRC_FRACTION = 2'h2,
    ODC_SRC_REFERENCE = 2'h3
  } odc_src_t;

  typedef enum logic [1:0] {
    ODC_ALIGN_IDLE = 2'b01,
    ODC_ALIGN_WAIT = 2'b10
  } odc_align_t;
endpackage

// [hdl/odc_int_divider.sv]
// Integer output divider with immediate or period-boundary updates
`include "odc_defs.svh"
module odc_int_divider (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Source clock edges, one per selector code
  input wire logic [3:0] src_edge,
  // Requested setting
  input wire odc_pkg::odc_src_t req_src,
  input wire logic [`ODC_DIV_W-1:0] req_div,
  input wire logic smooth_switch_select,
  input wire logic restart,
  // Divider state
  output logic div_clk_ff,
  output logic sel_edge
);
  import odc_pkg::*;

  odc_src_t act_src_ff;
  logic [`ODC_DIV_W-1:0] act_div_ff;
  logic [`ODC_DIV_W-1:0] cnt_ff;
  logic [`ODC_DIV_W-1:0] nxt_cnt;
  logic [`ODC_DIV_W-1:0] high_cnt;
  logic changed;
  logic at_bound;
  logic apply;

  assign sel_edge = src_edge[act_src_ff];
  assign changed = (req_src != act_src_ff) || (req_div != act_div_ff);
  assign at_bound = sel_edge && (cnt_ff == act_div_ff - 14'h0001);
  // Glitch-free: wait for the period end unless the divider is stopped
  assign apply = changed && (!smooth_switch_select ||
    (act_div_ff == 14'h0000) || at_bound);
  assign nxt_cnt = at_bound ? 14'h0000 : cnt_ff + 14'h0001;
  assign high_cnt = act_div_ff - (act_div_ff >> 1);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      act_src_ff <= ODC_SRC_PRESCALER_A;
      act_div_ff <= 14'h0000;
    end else if (apply) begin
      act_src_ff <= req_src;
      act_div_ff <= req_div;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_ff <= 14'h0000;
    end else if (restart || apply || act_div_ff == 14'h0000) begin
      cnt_ff <= 14'h0000;
    end else if (sel_edge) begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      div_clk_ff <= 1'b0;
    end else if (apply) begin
      div_clk_ff <= (req_div != 14'h0000);
    end else if (act_div_ff == 14'h0000) begin
      div_clk_ff <= 1'b0;
    end else if (restart) begin
      div_clk_ff <= 1'b1;
    end else if (sel_edge) begin
      div_clk_ff <= (nxt_cnt < high_cnt);
    end
  end

  a_smooth_holds: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    smooth_switch_select && act_div_ff != 14'h0000 && !at_bound
    |=> $stable(act_div_ff) && $stable(act_src_ff))
    else $error("setting changed inside an output period");

  a_immediate_load: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !smooth_switch_select && changed
    |=> act_div_ff == $past(req_div) && act_src_ff == $past(req_src))
    else $error("immediate mode did not load the setting");

  a_zero_stops: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    act_div_ff == 14'h0000 && !apply |=> !div_clk_ff)
    else $error("divider runs with a zero divide value");
endmodule

// [hdl/odc_channel_config.sv]
// Output channel divider configuration registers and output control
`include "odc_defs.svh"
module odc_channel_config (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [`ODC_ADDR_W-1:0] reg_addr,
  input wire logic [`ODC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`ODC_DATA_W-1:0] reg_rdata_ff,
  // Divider input clocks and control pins
  input wire logic prescaler_a,
  input wire logic prescaler_b,
  input wire logic fraction_clk,
  input wire logic reference_clk,
  input wire logic align_request,
  input wire logic override_active,
  input wire logic calibration_active,
  // Channel outputs
  output logic out_p_ff,
  output logic out_n_ff,
  output logic [15:0] fraction_upper_bits,
  output logic [8:0] fraction_lower_bits,
  output logic fraction_delay_select,
  output logic low_supply_indicator
);
  import odc_pkg::*;

  localparam int NPIN = 7;

  logic [`ODC_DATA_W-1:0] sw_ctrl_ff;
  logic [`ODC_DATA_W-1:0] supply_ff;
  logic [`ODC_DATA_W-1:0] frac_hi_ff;
  logic [`ODC_DATA_W-1:0] frac_lo_ff;
  logic [`ODC_DATA_W-1:0] int_div_ff;
  logic [`ODC_DATA_W-1:0] sync_out_ff;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] meta_ff;
  logic [NPIN-1:0] pin_ff;
  logic [NPIN-1:0] pin_old_ff;
  logic [3:0] src_edge;
  logic align_rise;
  logic smooth_switch_select;
  logic align_participate;
  logic silence_level_select;
  logic output_silence;
  logic silence;
  logic [`ODC_DLY_W-1:0] align_delay_cycles;
  logic [`ODC_DIV_W-1:0] integer_divide_value;
  odc_src_t integer_divider_source;
  odc_align_t align_ff;
  logic [`ODC_DLY_W-1:0] wait_ff;
  logic restart_ff;
  logic div_clk_ff;
  logic sel_edge;

  // Input pins pass two flip-flops before any use
  assign pin_raw = {calibration_active, override_active, align_request,
                    reference_clk, fraction_clk, prescaler_b, prescaler_a};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          meta_ff[gi] <= 1'b0;
          pin_ff[gi] <= 1'b0;
          pin_old_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= pin_raw[gi];
          pin_ff[gi] <= meta_ff[gi];
          pin_old_ff[gi] <= pin_ff[gi];
        end
      end
    end
  endgenerate
  assign src_edge = pin_ff[3:0] & ~pin_old_ff[3:0];
  assign align_rise = pin_ff[4] & ~pin_old_ff[4];

  // Field views
  assign smooth_switch_select = sw_ctrl_ff[`ODC_SW_SMOOTH_BIT];
  assign fraction_delay_select = sw_ctrl_ff[`ODC_SW_DELAY_MODE_BIT];
  assign low_supply_indicator = supply_ff[`ODC_SUP_LOW_BIT];
  assign fraction_upper_bits = frac_hi_ff;
  assign fraction_lower_bits = frac_lo_ff[`ODC_LO_MSB:0];
  assign integer_divider_source =
    odc_src_t'(int_div_ff[`ODC_ISRC_MSB:`ODC_ISRC_LSB]);
  assign integer_divide_value = int_div_ff[`ODC_IDIV_MSB:0];
  assign align_delay_cycles = sync_out_ff[`ODC_DLY_MSB:`ODC_DLY_LSB];
  assign align_participate = sync_out_ff[`ODC_ALIGN_EN_BIT];
  assign silence_level_select = sync_out_ff[`ODC_SIL_LVL_BIT];
  assign output_silence = sync_out_ff[`ODC_SIL_BIT];
  assign silence = pin_ff[5] ? output_silence
                             : (output_silence & pin_ff[6]);

  // Register writes
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sw_ctrl_ff <= `ODC_RST_SW_CTRL;
      supply_ff <= `ODC_RST_SUPPLY;
      frac_hi_ff <= `ODC_RST_FRAC_HI;
      frac_lo_ff <= `ODC_RST_FRAC_LO;
      int_div_ff <= `ODC_RST_INT_DIV;
      sync_out_ff <= `ODC_RST_SYNC_OUT;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `ODC_OFF_SW_CTRL: sw_ctrl_ff <= reg_wdata;
        `ODC_OFF_SUPPLY: supply_ff <= reg_wdata;
        `ODC_OFF_FRAC_HI: frac_hi_ff <= reg_wdata;
        `ODC_OFF_FRAC_LO: frac_lo_ff <= reg_wdata;
        `ODC_OFF_INT_DIV: int_div_ff <= reg_wdata;
        `ODC_OFF_SYNC_OUT: sync_out_ff <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Register reads, unmapped addresses return zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ODC_OFF_SW_CTRL: reg_rdata_ff <= sw_ctrl_ff;
        `ODC_OFF_SUPPLY: reg_rdata_ff <= supply_ff;
        `ODC_OFF_FRAC_HI: reg_rdata_ff <= frac_hi_ff;
        `ODC_OFF_FRAC_LO: reg_rdata_ff <= frac_lo_ff;
        `ODC_OFF_INT_DIV: reg_rdata_ff <= int_div_ff;
        `ODC_OFF_SYNC_OUT: reg_rdata_ff <= sync_out_ff;
        default: reg_rdata_ff <= 16'h0000;
      endcase
    end
  end

  // Alignment delay sequencer
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      align_ff <= ODC_ALIGN_IDLE;
      wait_ff <= 5'h00;
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= 1'b0;
      unique case (align_ff)
        ODC_ALIGN_IDLE: begin
          if (align_rise && align_participate) begin
            if (align_delay_cycles == 5'h00) begin
              restart_ff <= 1'b1;
            end else begin
              wait_ff <= align_delay_cycles;
              align_ff <= ODC_ALIGN_WAIT;
            end
          end
        end
        ODC_ALIGN_WAIT: begin
          if (sel_edge) begin
            wait_ff <= wait_ff - 5'h01;
            if (wait_ff == 5'h01) begin
              restart_ff <= 1'b1;
              align_ff <= ODC_ALIGN_IDLE;
            end
          end
        end
      endcase
    end
  end

  odc_int_divider odc_int_divider_i (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .src_edge(src_edge),
    .req_src(integer_divider_source),
    .req_div(integer_divide_value),
    .smooth_switch_select(smooth_switch_select),
    .restart(restart_ff),
    .div_clk_ff(div_clk_ff),
    .sel_edge(sel_edge)
  );

  // Output stage with mute levels
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      out_p_ff <= 1'b0;
      out_n_ff <= 1'b1;
    end else if (silence) begin
      out_p_ff <= silence_level_select;
      out_n_ff <= ~silence_level_select;
    end else begin
      out_p_ff <= div_clk_ff;
      out_n_ff <= ~div_clk_ff;
    end
  end

  sequence s_align_seen;
    align_rise && align_participate && align_ff == ODC_ALIGN_IDLE;
  endsequence

  sequence s_no_delay;
    s_align_seen ##0 align_delay_cycles == 5'h00;
  endsequence

  a_align_ignore: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    align_ff == ODC_ALIGN_IDLE && !align_participate |=> !restart_ff
      && align_ff == ODC_ALIGN_IDLE)
    else $error("alignment taken while disabled");

  a_align_zero: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    s_no_delay |=> restart_ff)
    else $error("zero delay alignment did not restart");

  a_align_wait: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    s_align_seen ##0 align_delay_cycles != 5'h00
    |=> align_ff == ODC_ALIGN_WAIT && wait_ff == $past(align_delay_cycles)
      && !restart_ff)
    else $error("alignment delay not loaded");

  a_mute_level: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    silence && !silence_level_select |=> !out_p_ff && out_n_ff)
    else $error("mute levels wrong");

  a_mute_calib: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !pin_ff[5] && !pin_ff[6] |=> out_n_ff == !out_p_ff
      && out_p_ff == $past(div_clk_ff))
    else $error("output muted outside calibration");

  a_reset_bits: assert property (
    @(posedge sys_clk)
    !resetn |=> smooth_switch_select && low_supply_indicator
      && !align_participate)
    else $error("reset values wrong");

  a_fraction_map: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `ODC_OFF_FRAC_LO
    |=> fraction_lower_bits == $past(reg_wdata[8:0]))
    else $error("lower fraction bits not taken");

  a_delay_mode: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `ODC_OFF_SW_CTRL
    |=> fraction_delay_select == $past(reg_wdata[15])
      && fraction_upper_bits == $past(frac_hi_ff))
    else $error("delay mode bit not taken");
endmodule

// [verification/odc_channel_config_tb_top.sv]
// Self-checking testbench for the output channel divider configuration block
module odc_channel_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, resetn, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata_ff, fraction_upper_bits;
  logic prescaler_a, prescaler_b, fraction_clk, reference_clk;
  logic align_request, override_active, calibration_active;
  logic out_p_ff, out_n_ff, fraction_delay_select, low_supply_indicator;
  logic [8:0] fraction_lower_bits;
  int miscompares, tests_run, n;
  logic [15:0] rst_v [6] = '{16'h0071, 16'h0008, 16'h8000, 16'h0000,
    16'h0000, 16'h0004};
  logic [15:0] src_e [4] = '{16'h001E, 16'h0014, 16'h000F, 16'h000C};

  odc_channel_config odc_channel_config_i (
    .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_ff, .prescaler_a, .prescaler_b, .fraction_clk,
    .reference_clk, .align_request, .override_active, .calibration_active,
    .out_p_ff, .out_n_ff, .fraction_upper_bits, .fraction_lower_bits,
    .fraction_delay_select, .low_supply_indicator
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Source clocks at 8, 12, 16 and 20 system cycles per period
  always #32 prescaler_a = ~prescaler_a;
  always #48 prescaler_b = ~prescaler_b;
  always #64 fraction_clk = ~fraction_clk;
  always #80 reference_clk = ~reference_clk;

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [15:0] exp);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk) #1;
    reg_rd = 1'b0;
    @(posedge sys_clk) #1;
    chk("rdata", reg_rdata_ff, exp);
  endtask

  // Counts rising edges of the positive output over a window
  task automatic edges(int cyc);
    logic prev;
    n = 0;
    prev = out_p_ff;
    repeat (cyc) begin
      @(posedge sys_clk) #1;
      if (out_p_ff === 1'b1 && prev === 1'b0) n++;
      prev = out_p_ff;
    end
  endtask

  // Waits for the positive output to fall, bounded
  task automatic fall;
    int k;
    for (k = 0; k < 400 && out_p_ff !== 1'b1; k++) @(posedge sys_clk) #1;
    for (k = 0; k < 400 && out_p_ff !== 1'b0; k++) @(posedge sys_clk) #1;
  endtask

  task automatic test_done;
    $display("counts run %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    test_done;
  end

  initial begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {prescaler_a, prescaler_b, fraction_clk, reference_clk} = '0;
    {align_request, override_active, calibration_active} = '0;
    repeat (4) @(posedge sys_clk);
    #1 resetn = 1'b1;
    chk("out_p", out_p_ff, 16'h0000);
    chk("out_n", out_n_ff, 16'h0001);
    chk("upper", fraction_upper_bits, 16'h8000);
    chk("supply", low_supply_indicator, 16'h0001);
    chk("mode", fraction_delay_select, 16'h0000);
    for (int i = 0; i < 6; i++) rd(8'h2D + 8'(i), rst_v[i]);
    wr(8'h33, 16'h1234);
    rd(8'h33, 16'h0000);
    $display("test reset done");
    wr(8'h2F, 16'hA5C3);
    wr(8'h30, 16'hFFFF);
    wr(8'h2E, 16'h0000);
    wr(8'h2D, 16'h8070);
    rd(8'h30, 16'hFFFF);
    chk("upper", fraction_upper_bits, 16'hA5C3);
    chk("lower", fraction_lower_bits, 16'h01FF);
    chk("supply", low_supply_indicator, 16'h0000);
    chk("mode", fraction_delay_select, 16'h0001);
    $display("test fields done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h31, {2'(s), 14'h0002});
      repeat (100) @(posedge sys_clk) #1;
      edges(480);
      chk("src edges", 16'(n), src_e[s]);
    end
    wr(8'h31, 16'h0000);
    repeat (20) @(posedge sys_clk) #1;
    edges(200);
    chk("off edges", 16'(n), 16'h0000);
    chk("off out_n", out_n_ff, 16'h0001);
    $display("test divider done");
    wr(8'h31, 16'h0004);
    repeat (100) @(posedge sys_clk) #1;
    fall;
    wr(8'h31, 16'h0003);
    repeat (2) @(posedge sys_clk) #1;
    chk("immediate", out_p_ff, 16'h0001);
    wr(8'h2D, 16'h0071);
    wr(8'h31, 16'h0004);
    repeat (100) @(posedge sys_clk) #1;
    fall;
    wr(8'h31, 16'h0003);
    repeat (4) @(posedge sys_clk) #1;
    chk("smooth", out_p_ff, 16'h0000);
    wr(8'h31, 16'h0004);
    $display("test switching done");
    for (int j = 0; j < 3; j++) begin
      wr(8'h32, j == 0 ? 16'h0004 : (j == 1 ? 16'h0404 : 16'h1C04));
      repeat (100) @(posedge sys_clk) #1;
      fall;
      align_request = 1'b1;
      repeat (9) @(posedge sys_clk) #1;
      chk("align", out_p_ff, 16'(j == 1));
      align_request = 1'b0;
      if (j == 2) begin
        repeat (26) @(posedge sys_clk) #1;
        chk("delayed", out_p_ff, 16'h0001);
      end
    end
    $display("test align done");
    override_active = 1'b1;
    wr(8'h32, 16'h0084);
    repeat (6) @(posedge sys_clk) #1;
    edges(64);
    chk("mute edges", 16'(n), 16'h0000);
    chk("mute p", out_p_ff, 16'h0000);
    chk("mute n", out_n_ff, 16'h0001);
    wr(8'h32, 16'h0184);
    repeat (6) @(posedge sys_clk) #1;
    chk("mute hi p", out_p_ff, 16'h0001);
    chk("mute hi n", out_n_ff, 16'h0000);
    override_active = 1'b0;
    repeat (6) @(posedge sys_clk) #1;
    edges(64);
    chk("calib off", 16'(n), 16'h0002);
    calibration_active = 1'b1;
    repeat (6) @(posedge sys_clk) #1;
    edges(64);
    chk("calib on", 16'(n), 16'h0000);
    chk("calib p", out_p_ff, 16'h0001);
    $display("test mute done");
    test_done;
  end
endmodule
